// *** rtl/core_reset_pkg.sv ***
// Package: constants and types for the core register reset initialiser
`default_nettype none
package core_reset_pkg;

    // Reset classes, one-hot
    typedef enum logic [4:0] {
        CLS_NONE          = 5'b00001,
        CLS_COLD          = 5'b00010,
        CLS_WARM          = 5'b00100,
        CLS_WAKE_WATCHDOG = 5'b01000,
        CLS_WAKE_IRQ      = 5'b10000
    } reset_class_t;

    localparam int PC_W = 21;
    localparam int SEL_W = 5;

    // Register select codes for the core access port
    localparam logic [4:0] SEL_STACK_TOP_UPPER  = 5'h00;
    localparam logic [4:0] SEL_STACK_TOP_HIGH   = 5'h01;
    localparam logic [4:0] SEL_STACK_TOP_LOW    = 5'h02;
    localparam logic [4:0] SEL_RETURN_STACK_PTR = 5'h03;
    localparam logic [4:0] SEL_PC_LATCH_UPPER   = 5'h04;
    localparam logic [4:0] SEL_PC_LATCH_HIGH    = 5'h05;
    localparam logic [4:0] SEL_PC_LOW_BYTE      = 5'h06;
    localparam logic [4:0] SEL_TABLE_PTR_UPPER  = 5'h07;
    localparam logic [4:0] SEL_TABLE_PTR_HIGH   = 5'h08;
    localparam logic [4:0] SEL_TABLE_PTR_LOW    = 5'h09;
    localparam logic [4:0] SEL_TABLE_LATCH      = 5'h0A;
    localparam logic [4:0] SEL_PRODUCT_HIGH     = 5'h0B;
    localparam logic [4:0] SEL_PRODUCT_LOW      = 5'h0C;
    localparam logic [4:0] SEL_IRQ_CTRL_MAIN    = 5'h0D;
    localparam logic [4:0] SEL_IRQ_CTRL_SECOND  = 5'h0E;
    localparam logic [4:0] SEL_IRQ_CTRL_THIRD   = 5'h0F;
    localparam logic [4:0] SEL_IND_PTR0_HIGH    = 5'h10;
    localparam logic [4:0] SEL_IND_PTR0_LOW     = 5'h11;
    localparam logic [4:0] SEL_WORKING_REG      = 5'h12;

    // Implemented-bit masks
    localparam logic [7:0] MASK_5BIT        = 8'h1F;
    localparam logic [7:0] MASK_6BIT        = 8'h3F;
    localparam logic [7:0] MASK_4BIT        = 8'h0F;
    localparam logic [7:0] MASK_STACK_PTR   = 8'hDF;
    localparam logic [7:0] MASK_IRQ_SECOND  = 8'hF5;
    localparam logic [7:0] MASK_IRQ_THIRD   = 8'hDB;
    localparam logic [7:0] MASK_FULL        = 8'hFF;

    // Reset values
    localparam logic [7:0] RST_IRQ_SECOND   = 8'hF5;
    localparam logic [7:0] RST_IRQ_THIRD    = 8'hC0;

    // Field positions
    localparam int IRQ_EN_HIGH_BIT = 7;
    localparam int IRQ_EN_LOW_BIT  = 6;
    localparam int STK_FULL_BIT    = 7;
    localparam int STK_UNF_BIT     = 6;

    // Interrupt vectors and wake step
    localparam logic [20:0] VEC_HIGH = 21'h000008;
    localparam logic [20:0] VEC_LOW  = 21'h000018;
    localparam logic [20:0] PC_STEP  = 21'h000002;

endpackage : core_reset_pkg
`default_nettype wire

// *** rtl/core_reset_if.sv ***
// Interface: reset-class decode handshake between the top and its decoder
`timescale 1ns/100ps
`default_nettype none
interface core_reset_if;
    import core_reset_pkg::*;
    logic         cold_req;
    logic         warm_req;
    logic         wake_watchdog;
    logic         wake_irq;
    logic         irq_low_prio;
    logic         irq_en_high;
    logic         irq_en_low;
    reset_class_t cls;
    logic         take_vector;
    logic [20:0]  vector;

    modport top (output cold_req, warm_req, wake_watchdog, wake_irq, irq_low_prio,
                 output irq_en_high, irq_en_low, input cls, take_vector, vector);
    modport dec (input cold_req, warm_req, wake_watchdog, wake_irq, irq_low_prio,
                 input irq_en_high, irq_en_low, output cls, take_vector, vector);
endinterface : core_reset_if
`default_nettype wire

// *** rtl/reset_class_decode.sv ***
// Decoder: picks the reset class and the wake-up vector
`timescale 1ns/100ps
`default_nettype none
module reset_class_decode
    import core_reset_pkg::*;
(
    core_reset_if.dec rif
);

    // Cold beats warm beats wake; simultaneous wake causes are served as interrupt
    always_comb begin
        rif.cls         = CLS_NONE;
        rif.take_vector = 1'b0;
        rif.vector      = VEC_HIGH;
        if (rif.cold_req) begin
            rif.cls = CLS_COLD;
        end else if (rif.warm_req) begin
            rif.cls = CLS_WARM;
        end else if (rif.wake_irq) begin
            rif.cls = CLS_WAKE_IRQ;
            if (!rif.irq_low_prio && rif.irq_en_high) begin
                rif.take_vector = 1'b1;
            end else if (rif.irq_low_prio && rif.irq_en_low) begin
                rif.take_vector = 1'b1;
                rif.vector      = VEC_LOW;
            end
        end else if (rif.wake_watchdog) begin
            rif.cls = CLS_WAKE_WATCHDOG;
        end
    end

endmodule : reset_class_decode
`default_nettype wire

// *** rtl/core_register_reset_init.sv ***
// Core special-register bank with per-class reset initialisation
`timescale 1ns/100ps
`default_nettype none
module core_register_reset_init
    import core_reset_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_b_i,
    // Reset and wake events (one-cycle pulses), plus the wake priority and wake flag index
    input  wire logic        cold_reset_i,
    input  wire logic        warm_reset_i,
    input  wire logic        wake_watchdog_i,
    input  wire logic        wake_irq_i,
    input  wire logic        irq_low_prio_i,
    input  wire logic [2:0]  wake_flag_idx_i,
    // Core access port
    input  wire logic        wr_en_i,
    input  wire logic [4:0]  wr_sel_i,
    input  wire logic [7:0]  wr_data_i,
    input  wire logic [4:0]  rd_sel_i,
    input  wire logic        pc_step_i,
    // Outputs
    output var  logic [7:0]  rd_data_o,
    output var  logic [20:0] pc_o,
    output var  logic        vector_taken_o
);

    logic [20:0] stack_top;
    logic [7:0]  return_stack_pointer;
    logic [4:0]  pc_latch_upper;
    logic [7:0]  pc_latch_high;
    logic [20:0] pc;
    logic [21:0] table_pointer;
    logic [7:0]  table_latch;
    logic [15:0] product;
    logic [7:0]  interrupt_control_main;
    logic [7:0]  interrupt_control_second;
    logic [7:0]  interrupt_control_third;
    logic [11:0] indirect_pointer0;
    logic [7:0]  working_register;
    logic        wr_ok;

    core_reset_if rif ();

    reset_class_decode u_decode (
        .rif (rif)
    );

    assign rif.cold_req      = cold_reset_i;
    assign rif.warm_req      = warm_reset_i;
    assign rif.wake_watchdog = wake_watchdog_i;
    assign rif.wake_irq      = wake_irq_i;
    assign rif.irq_low_prio  = irq_low_prio_i;
    assign rif.irq_en_high   = interrupt_control_main[IRQ_EN_HIGH_BIT];
    assign rif.irq_en_low    = interrupt_control_main[IRQ_EN_LOW_BIT];

    // Software writes lose to any reset or wake event in the same cycle
    assign wr_ok = wr_en_i && (rif.cls == CLS_NONE);

    function automatic logic [7:0] impl_mask(input logic [4:0] sel);
        case (sel)
            SEL_STACK_TOP_UPPER, SEL_PC_LATCH_UPPER: impl_mask = MASK_5BIT;
            SEL_TABLE_PTR_UPPER:                     impl_mask = MASK_6BIT;
            SEL_RETURN_STACK_PTR:                    impl_mask = MASK_STACK_PTR;
            SEL_IRQ_CTRL_SECOND:                     impl_mask = MASK_IRQ_SECOND;
            SEL_IRQ_CTRL_THIRD:                      impl_mask = MASK_IRQ_THIRD;
            SEL_IND_PTR0_HIGH:                       impl_mask = MASK_4BIT;
            default:                                 impl_mask = MASK_FULL;
        endcase
    endfunction : impl_mask

    function automatic logic wr_hit(input logic ok, input logic [4:0] s, input logic [4:0] t);
        wr_hit = ok && (s == t);
    endfunction : wr_hit

    ////////////////////////////////////////////////////////////////////////////
    // Return stack top and pointer
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stack_top <= 21'h000000;
        end else if (rif.cls == CLS_COLD || rif.cls == CLS_WARM) begin
            stack_top <= 21'h000000;
        end else if (rif.take_vector) begin
            stack_top <= pc;
        end else if (wr_hit(wr_ok, wr_sel_i, SEL_STACK_TOP_UPPER)) begin
            stack_top[20:16] <= wr_data_i[4:0];
        end else if (wr_hit(wr_ok, wr_sel_i, SEL_STACK_TOP_HIGH)) begin
            stack_top[15:8] <= wr_data_i;
        end else if (wr_hit(wr_ok, wr_sel_i, SEL_STACK_TOP_LOW)) begin
            stack_top[7:0] <= wr_data_i;
        end
    end

    // Warm resets keep the full and underflow flags
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            return_stack_pointer <= 8'h00;
        end else if (rif.cls == CLS_COLD) begin
            return_stack_pointer <= 8'h00;
        end else if (rif.cls == CLS_WARM) begin
            return_stack_pointer <= {return_stack_pointer[7:6], 6'h00};
        end else if (rif.take_vector) begin
            return_stack_pointer[4:0] <= return_stack_pointer[4:0] + 5'h01;
        end else if (wr_hit(wr_ok, wr_sel_i, SEL_RETURN_STACK_PTR)) begin
            return_stack_pointer <= wr_data_i & MASK_STACK_PTR;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Program counter and latches
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pc <= 21'h000000;
        end else if (rif.cls == CLS_COLD || rif.cls == CLS_WARM) begin
            pc <= 21'h000000;
        end else if (rif.take_vector) begin
            pc <= rif.vector;
        end else if (rif.cls == CLS_WAKE_IRQ || rif.cls == CLS_WAKE_WATCHDOG) begin
            pc <= 21'(pc + PC_STEP);
        end else if (wr_hit(wr_ok, wr_sel_i, SEL_PC_LOW_BYTE)) begin
            pc <= {pc_latch_upper, pc_latch_high, wr_data_i};
        end else if (pc_step_i) begin
            pc <= 21'(pc + PC_STEP);
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pc_latch_upper <= 5'h00;
            pc_latch_high  <= 8'h00;
        end else if (rif.cls == CLS_COLD || rif.cls == CLS_WARM) begin
            pc_latch_upper <= 5'h00;
            pc_latch_high  <= 8'h00;
        end else if (wr_hit(wr_ok, wr_sel_i, SEL_PC_LATCH_UPPER)) begin
            pc_latch_upper <= wr_data_i[4:0];
        end else if (wr_hit(wr_ok, wr_sel_i, SEL_PC_LATCH_HIGH)) begin
            pc_latch_high <= wr_data_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Table pointer and latch
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            table_pointer <= 22'h000000;
            table_latch   <= 8'h00;
        end else if (rif.cls == CLS_COLD || rif.cls == CLS_WARM) begin
            table_pointer <= 22'h000000;
            table_latch   <= 8'h00;
        end else if (wr_ok) begin
            case (wr_sel_i)
                SEL_TABLE_PTR_UPPER: table_pointer[21:16] <= wr_data_i[5:0];
                SEL_TABLE_PTR_HIGH:  table_pointer[15:8] <= wr_data_i;
                SEL_TABLE_PTR_LOW:   table_pointer[7:0] <= wr_data_i;
                SEL_TABLE_LATCH:     table_latch <= wr_data_i;
                default:             table_latch <= table_latch;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Unknown-at-power-on registers: never touched by any reset class
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            product           <= 16'h0000;
            indirect_pointer0 <= 12'h000;
            working_register  <= 8'h00;
        end else if (wr_ok) begin
            case (wr_sel_i)
                SEL_PRODUCT_HIGH:  product[15:8] <= wr_data_i;
                SEL_PRODUCT_LOW:   product[7:0] <= wr_data_i;
                SEL_IND_PTR0_HIGH: indirect_pointer0[11:8] <= wr_data_i[3:0];
                SEL_IND_PTR0_LOW:  indirect_pointer0[7:0] <= wr_data_i;
                SEL_WORKING_REG:   working_register <= wr_data_i;
                default:           working_register <= working_register;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt control; the wake flag is set even if a write clears it
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            interrupt_control_main   <= 8'h00;
            interrupt_control_second <= RST_IRQ_SECOND;
            interrupt_control_third  <= RST_IRQ_THIRD;
        end else if (rif.cls == CLS_COLD || rif.cls == CLS_WARM) begin
            interrupt_control_main   <= {7'h00, interrupt_control_main[0]};
            interrupt_control_second <= RST_IRQ_SECOND;
            interrupt_control_third  <= RST_IRQ_THIRD;
        end else if (rif.cls == CLS_WAKE_IRQ) begin
            interrupt_control_main[wake_flag_idx_i] <= 1'b1;
        end else if (wr_ok) begin
            case (wr_sel_i)
                SEL_IRQ_CTRL_MAIN:   interrupt_control_main <= wr_data_i;
                SEL_IRQ_CTRL_SECOND: interrupt_control_second <= wr_data_i & MASK_IRQ_SECOND;
                SEL_IRQ_CTRL_THIRD:  interrupt_control_third <= wr_data_i & MASK_IRQ_THIRD;
                default:             interrupt_control_main <= interrupt_control_main;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered read port and status outputs
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_data_o <= 8'h00;
        end else begin
            case (rd_sel_i)
                SEL_STACK_TOP_UPPER:  rd_data_o <= {3'h0, stack_top[20:16]};
                SEL_STACK_TOP_HIGH:   rd_data_o <= stack_top[15:8];
                SEL_STACK_TOP_LOW:    rd_data_o <= stack_top[7:0];
                SEL_RETURN_STACK_PTR: rd_data_o <= return_stack_pointer & impl_mask(rd_sel_i);
                SEL_PC_LATCH_UPPER:   rd_data_o <= {3'h0, pc_latch_upper};
                SEL_PC_LATCH_HIGH:    rd_data_o <= pc_latch_high;
                SEL_PC_LOW_BYTE:      rd_data_o <= pc[7:0];
                SEL_TABLE_PTR_UPPER:  rd_data_o <= {2'h0, table_pointer[21:16]};
                SEL_TABLE_PTR_HIGH:   rd_data_o <= table_pointer[15:8];
                SEL_TABLE_PTR_LOW:    rd_data_o <= table_pointer[7:0];
                SEL_TABLE_LATCH:      rd_data_o <= table_latch;
                SEL_PRODUCT_HIGH:     rd_data_o <= product[15:8];
                SEL_PRODUCT_LOW:      rd_data_o <= product[7:0];
                SEL_IRQ_CTRL_MAIN:    rd_data_o <= interrupt_control_main;
                SEL_IRQ_CTRL_SECOND:  rd_data_o <= interrupt_control_second & impl_mask(rd_sel_i);
                SEL_IRQ_CTRL_THIRD:   rd_data_o <= interrupt_control_third & impl_mask(rd_sel_i);
                SEL_IND_PTR0_HIGH:    rd_data_o <= {4'h0, indirect_pointer0[11:8]};
                SEL_IND_PTR0_LOW:     rd_data_o <= indirect_pointer0[7:0];
                SEL_WORKING_REG:      rd_data_o <= working_register;
                default:              rd_data_o <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pc_o           <= 21'h000000;
            vector_taken_o <= 1'b0;
        end else begin
            pc_o           <= pc;
            vector_taken_o <= rif.take_vector;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_cold_clears;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        cold_reset_i |=> (stack_top == 21'h0) && (return_stack_pointer == 8'h00)
                         && (pc == 21'h0) ##1 (pc_o == 21'h0);
    endproperty
    a_cold_clears: assert property (p_cold_clears) else $error("cold reset left state");

    property p_unimpl_zero;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (rd_sel_i == SEL_RETURN_STACK_PTR) |=> (rd_data_o[5] == 1'b0);
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit read one");

    property p_vector_high;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (wake_irq_i && !cold_reset_i && !warm_reset_i && !irq_low_prio_i
         && interrupt_control_main[IRQ_EN_HIGH_BIT]) |=> vector_taken_o ##1 (pc_o == VEC_HIGH);
    endproperty
    a_vector_high: assert property (p_vector_high) else $error("high vector not loaded");

    property p_tos_copy;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        rif.take_vector |=> (stack_top == $past(pc));
    endproperty
    a_tos_copy: assert property (p_tos_copy) else $error("stack top not loaded");

    property p_ptr_advance;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        rif.take_vector |=> (return_stack_pointer[4:0] == 5'($past(return_stack_pointer[4:0]) + 5'h01));
    endproperty
    a_ptr_advance: assert property (p_ptr_advance) else $error("stack pointer not advanced");

    property p_wake_flag;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (rif.cls == CLS_WAKE_IRQ) |=> (interrupt_control_main[$past(wake_flag_idx_i)] == 1'b1);
    endproperty
    a_wake_flag: assert property (p_wake_flag) else $error("wake flag not set");

    property p_retain_product;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (warm_reset_i || cold_reset_i) |=> $stable(product) && $stable(working_register)
                                           && (table_latch == 8'h00);
    endproperty
    a_retain_product: assert property (p_retain_product) else $error("retention broken");

    c_cold: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i) cold_reset_i);
    c_vector: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i) vector_taken_o);
    c_watchdog_wake: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        rif.cls == CLS_WAKE_WATCHDOG);

endmodule : core_register_reset_init
`default_nettype wire

// *** sim/testbench.sv ***
// Testbench: directed and random stimulus compared against a reference model of the bank
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import core_reset_pkg::*;

    logic        clk_sys_i;
    logic        rst_b_i;
    logic        cold_reset_i;
    logic        warm_reset_i;
    logic        wake_watchdog_i;
    logic        wake_irq_i;
    logic        irq_low_prio_i;
    logic [2:0]  wake_flag_idx_i;
    logic        wr_en_i;
    logic [4:0]  wr_sel_i;
    logic [7:0]  wr_data_i;
    logic [4:0]  rd_sel_i;
    logic        pc_step_i;
    logic [7:0]  rd_data_o;
    logic [20:0] pc_o;
    logic        vector_taken_o;
    int          num_errors;
    int          comparisons;
    int          seed;
    int          rnd;
    int          op;
    int          regs [0:18];
    int          pc;
    logic        en_m;
    logic [7:0]  exp_rd;
    logic [20:0] exp_pc;
    logic        exp_vt;
    localparam logic [7:0] RD_MASK [0:18] = '{MASK_5BIT, MASK_FULL, MASK_FULL, MASK_STACK_PTR,
        MASK_5BIT, MASK_FULL, MASK_FULL, MASK_6BIT, MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL,
        MASK_FULL, MASK_FULL, MASK_IRQ_SECOND, MASK_IRQ_THIRD, MASK_4BIT, MASK_FULL, MASK_FULL};

    core_register_reset_init u_dut (
        .clk_sys_i      (clk_sys_i),
        .rst_b_i        (rst_b_i),
        .cold_reset_i   (cold_reset_i),
        .warm_reset_i   (warm_reset_i),
        .wake_watchdog_i(wake_watchdog_i),
        .wake_irq_i     (wake_irq_i),
        .irq_low_prio_i (irq_low_prio_i),
        .wake_flag_idx_i(wake_flag_idx_i),
        .wr_en_i        (wr_en_i),
        .wr_sel_i       (wr_sel_i),
        .wr_data_i      (wr_data_i),
        .rd_sel_i       (rd_sel_i),
        .pc_step_i      (pc_step_i),
        .rd_data_o      (rd_data_o),
        .pc_o           (pc_o),
        .vector_taken_o (vector_taken_o)
    );

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [20:0] seen, input logic [20:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic results;
        if (num_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results

    task automatic model_reset;
        foreach (regs[i]) regs[i] = 0;
        regs[14] = RST_IRQ_SECOND;
        regs[15] = RST_IRQ_THIRD;
        pc = 0;
        exp_rd = 8'h00;
        exp_pc = 21'h000000;
        exp_vt = 1'b0;
    endtask : model_reset

    function automatic logic [7:0] model_read(input logic [4:0] sel);
        int v;
        if (sel > SEL_WORKING_REG) return 8'h00;
        v = (sel == SEL_PC_LOW_BYTE) ? pc : regs[sel];
        return v[7:0] & RD_MASK[sel];
    endfunction : model_read

    ////////////////////////////////////////////////////////////////////////////////////////
    // Model steps on the same edge the design samples; inputs still hold their old values
    always @(posedge clk_sys_i) begin
        if (rst_b_i) begin
            exp_rd = model_read(rd_sel_i);
            exp_pc = pc[20:0];
            exp_vt = 1'b0;
            if (cold_reset_i || warm_reset_i) begin
                for (int i = 0; i <= 10; i++) begin
                    regs[i] = (i == 3 && !cold_reset_i) ? regs[3] & 8'hC0 : 0;
                end
                pc = 0;
                regs[13] = regs[13] & 8'h01;
                regs[14] = RST_IRQ_SECOND;
                regs[15] = RST_IRQ_THIRD;
            end else if (wake_irq_i) begin
                en_m = irq_low_prio_i ? regs[13][IRQ_EN_LOW_BIT] : regs[13][IRQ_EN_HIGH_BIT];
                regs[13] = regs[13] | (1 << wake_flag_idx_i);
                if (en_m) begin
                    regs[0] = (pc >> 16) & 8'h1F;
                    regs[1] = (pc >> 8) & 8'hFF;
                    regs[2] = pc & 8'hFF;
                    regs[3] = (regs[3] & 8'hE0) | ((regs[3] + 1) & 8'h1F);
                    pc = irq_low_prio_i ? VEC_LOW : VEC_HIGH;
                    exp_vt = 1'b1;
                end else begin
                    pc = (pc + 2) & 21'h1FFFFF;
                end
            end else if (wake_watchdog_i) begin
                pc = (pc + 2) & 21'h1FFFFF;
            end else begin
                // Only a write of the pc itself holds off a pc step
                if (wr_en_i && wr_sel_i <= SEL_WORKING_REG && wr_sel_i != SEL_PC_LOW_BYTE) begin
                    regs[wr_sel_i] = wr_data_i & RD_MASK[wr_sel_i];
                end
                if (wr_en_i && wr_sel_i == SEL_PC_LOW_BYTE) begin
                    pc = (regs[4] << 16) | (regs[5] << 8) | wr_data_i;
                end else if (pc_step_i) begin
                    pc = (pc + 2) & 21'h1FFFFF;
                end
            end
        end
    end

    // Reset is asynchronous, so outputs are judged against zero while it is held
    always @(negedge clk_sys_i) begin
        if (!rst_b_i) model_reset();
        check("rd_data_o", {13'h0, rd_data_o}, {13'h0, exp_rd});
        check("pc_o", pc_o, exp_pc);
        check("vector_taken_o", {20'h0, vector_taken_o}, {20'h0, exp_vt});
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input logic [3:0] ev, input logic lowp, input logic [2:0] idx,
                       input logic wen, input logic [4:0] wsel, input logic [7:0] wdat,
                       input logic [4:0] rsel, input logic stp);
        @(posedge clk_sys_i);
        {wake_irq_i, wake_watchdog_i, warm_reset_i, cold_reset_i} <= ev;
        irq_low_prio_i <= lowp;
        wake_flag_idx_i <= idx;
        wr_en_i <= wen;
        wr_sel_i <= wsel;
        wr_data_i <= wdat;
        rd_sel_i <= rsel;
        pc_step_i <= stp;
    endtask : cyc

    task automatic wr(input logic [4:0] sel, input logic [7:0] dat);
        cyc(4'h0, 1'b0, 3'h0, 1'b1, sel, dat, SEL_WORKING_REG, 1'b0);
    endtask : wr

    task automatic rd(input logic [4:0] sel, output logic [7:0] val);
        cyc(4'h0, 1'b0, 3'h0, 1'b0, 5'h00, 8'h00, sel, 1'b0);
        cyc(4'h0, 1'b0, 3'h0, 1'b0, 5'h00, 8'h00, sel, 1'b0);
        @(negedge clk_sys_i);
        val = rd_data_o;
    endtask : rd

    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    // Whole run needs about 2500 cycles; the limit leaves generous slack
    initial begin
        repeat (6000) @(posedge clk_sys_i);
        num_errors++;
        results();
    end

    initial begin
        logic [7:0] v;
        num_errors = 0;
        comparisons = 0;
        seed = 49;
        rst_b_i = 1'b0;
        cyc(4'h0, 1'b0, 3'h0, 1'b0, 5'h00, 8'h00, 5'h00, 1'b0);
        repeat (20) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        cyc(4'h1, 1'b0, 3'h0, 1'b0, 5'h00, 8'h00, 5'h00, 1'b0);
        wr(SEL_PC_LATCH_UPPER, 8'h01);
        wr(SEL_PC_LATCH_HIGH, 8'h23);
        wr(SEL_PC_LOW_BYTE, 8'h45);
        wr(SEL_IRQ_CTRL_MAIN, 8'h80);
        wr(SEL_PRODUCT_HIGH, 8'hA5);
        wr(SEL_TABLE_PTR_LOW, 8'h5A);
        cyc(4'h8, 1'b0, 3'h2, 1'b0, 5'h00, 8'h00, 5'h00, 1'b0);
        rd(SEL_STACK_TOP_LOW, v);
        check("stack_top_low", {13'h0, v}, 21'h000045);
        rd(SEL_STACK_TOP_UPPER, v);
        check("stack_top_upper", {13'h0, v}, 21'h000001);
        rd(SEL_RETURN_STACK_PTR, v);
        check("return_stack_pointer", {13'h0, v}, 21'h000001);
        rd(SEL_IRQ_CTRL_MAIN, v);
        check("interrupt_control_main", {13'h0, v}, 21'h000084);
        wr(SEL_IRQ_CTRL_MAIN, 8'h40);
        cyc(4'h8, 1'b1, 3'h1, 1'b0, 5'h00, 8'h00, 5'h00, 1'b0);
        rd(SEL_PC_LOW_BYTE, v);
        check("pc_low_byte", {13'h0, v}, {13'h0, VEC_LOW[7:0]});
        cyc(4'h2, 1'b0, 3'h0, 1'b0, 5'h00, 8'h00, 5'h00, 1'b0);
        rd(SEL_PRODUCT_HIGH, v);
        check("product_high", {13'h0, v}, 21'h0000A5);
        rd(SEL_TABLE_PTR_LOW, v);
        check("table_pointer_low", {13'h0, v}, 21'h000000);
        cyc(4'h8, 1'b0, 3'h3, 1'b0, 5'h00, 8'h00, 5'h00, 1'b0);
        rd(SEL_IRQ_CTRL_MAIN, v);
        check("interrupt_control_main", {13'h0, v}, 21'h000008);
        cyc(4'h4, 1'b0, 3'h0, 1'b0, 5'h00, 8'h00, 5'h00, 1'b0);
        rd(SEL_PC_LOW_BYTE, v);
        check("pc_low_byte", {13'h0, v}, 21'h000004);
        // Random traffic; writes also collide with events and pc steps, and hit the stack pointer
        for (int n = 0; n < 2400; n++) begin
            op = {$random(seed)} % 16;
            rnd = $random(seed);
            if (n == 1200) begin
                rst_b_i <= 1'b0;
                repeat (3) @(posedge clk_sys_i);
                rst_b_i <= 1'b1;
            end
            cyc((op == 0) ? 4'h1 : (op == 1) ? 4'h2 : (op == 2) ? 4'h4 : (op < 5) ? 4'h8 : 4'h0,
                rnd[8], 3'({rnd[11:9]} % 6), (op >= 5 && op <= 10) || rnd[30],
                rnd[16:12], rnd[24:17], rnd[29:25], (op >= 11 && op <= 13) || rnd[31]);
        end
        cyc(4'h0, 1'b0, 3'h0, 1'b0, 5'h00, 8'h00, 5'h00, 1'b0);
        repeat (3) @(posedge clk_sys_i);
        results();
    end

endmodule : testbench
`default_nettype wire
